/* lafc_asserts.sv */
// Checker for the octet link between the address field ends
`timescale 1ns/10ps
`default_nettype none
module lafc_asserts (
  input wire logic clk_sys,        // System clock
  input wire logic sys_rst,        // Synchronous reset
  input wire logic oct_valid,      // Octet offered
  input wire logic oct_ready,      // Buffer room
  input wire logic [7:0] oct_data, // Octet
  input wire logic oct_last        // Final octet
);
  logic take, mark, fin, ext_now, in_dst, next_in_dst, hold, next_hold;
  logic [2:0] left, next_left;
  logic [4:0] cnt, next_cnt;

  // Decode of the octet on the link
  assign take = oct_valid && oct_ready;
  assign mark = (left == 3'h0) && (oct_data[7:1] == lafc_pkg::MARK_VAL);
  assign fin = (left == 3'h1) || ((left == 3'h0) && !mark);
  assign ext_now = (left == 3'h1) ? hold : oct_data[0];

  // Position inside the address field
  always_comb
  begin
    next_left = left;
    next_in_dst = in_dst;
    next_hold = hold;
    next_cnt = cnt;
    if (take && oct_last)
    begin
      next_left = 3'h0;
      next_in_dst = 1'b0;
      next_cnt = 5'h00;
    end
    else if (take)
    begin
      if (mark)
        next_left = 3'h4;
      else if (left != 3'h0)
        next_left = left - 3'h1;
      if (mark)
        next_hold = oct_data[0];
      if (fin)
        next_in_dst = 1'b1;
      if (fin && in_dst)
        next_cnt = cnt + 5'h01;
    end
  end

  // Position registers
  always_ff @(posedge clk_sys)
    {left, in_dst, hold, cnt} <= sys_rst ? '0 :
      {next_left, next_in_dst, next_hold, next_cnt};

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_take;
    oct_valid && oct_ready;
  endsequence
  sequence s_end;
    s_take ##0 oct_last;
  endsequence

  a_offer_holds:
    assert property (oct_valid && !oct_ready |=> oct_valid &&
      $stable(oct_data) && $stable(oct_last)) else $error("Octet moved");
  a_reset_idle:
    assert property (disable iff (1'b0) sys_rst |=> !oct_valid)
      else $error("Octet offered in reset");
  a_ready_wakes:
    assert property ($fell(sys_rst) |=> oct_ready)
      else $error("Buffer not ready after reset");
  a_marker_body:
    assert property (s_take ##0 mark |-> !oct_last)
      else $error("Frame ends at a marker");
  a_list_ends:
    assert property (s_end |-> in_dst && fin &&
      ext_now == lafc_pkg::EXT_END) else $error("List not terminated");
  a_ext_chains:
    assert property (s_take ##0 (!oct_last && in_dst && fin) |->
      ext_now == lafc_pkg::EXT_MORE) else $error("Early list end");
  a_src_first:
    assert property (s_take ##0 (!in_dst && fin) |-> !oct_last)
      else $error("No destination after source");
  a_dst_sixteen:
    assert property (s_take ##0 (in_dst && fin && cnt == 5'h0f) |->
      oct_last) else $error("More than sixteen destinations");
endmodule : lafc_asserts
`default_nettype wire

/* lafc_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module lafc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,              // System clock
  input wire logic sys_rst,              // Synchronous reset
  input wire logic in_valid,             // Write request
  output logic in_ready,                 // Room for one word
  input wire logic [WIDTH-1:0] in_data,  // Write data
  output logic out_valid,                // Word available
  input wire logic out_ready,            // Reader takes word
  output logic [WIDTH-1:0] out_data      // Head word
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] CNT_EMPTY = '0;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic next_in_ready, next_out_valid, push, pop;

  // Pointer and level update; flags are kept in flops
  always_comb
  begin
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    next_in_ready = next_count != CNT_FULL;
    next_out_valid = next_count != CNT_EMPTY;
  end

  // Registered state
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready <= next_in_ready;
      out_valid <= next_out_valid;
    end
  end

  // Storage
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  assign out_data = mem[rd_ptr];
endmodule : lafc_fifo
`default_nettype wire

/* lafc_link_if.sv */
// Octet stream between the sending station and the receiving station
`timescale 1ns/10ps
`default_nettype none
interface lafc_link_if (
  input wire logic clk_sys  // System clock
);
  logic oct_valid;
  logic oct_ready;
  logic [7:0] oct_data;
  logic oct_last;

  // Sending station end
  modport tx (
    output oct_valid,
    output oct_data,
    output oct_last,
    input oct_ready
  );

  // Receiving station end
  modport rx (
    input oct_valid,
    input oct_data,
    input oct_last,
    output oct_ready
  );
endinterface : lafc_link_if
`default_nettype wire

/* lafc_pkg.sv */
// Shared constants and state types for the link address field codec
`default_nettype none
package lafc_pkg;
  // Octet layout
  localparam int OCT_W = 8;
  localparam int ADR_W = 32;
  localparam int FIFO_W = 9;
  localparam int FIFO_D = 8;
  localparam int LAST_BIT = 8;
  // Marker value in the seven address bits of a wide-address marker
  localparam logic [6:0] MARK_VAL = 7'h7e;
  // Reserved zero address
  localparam logic [6:0] ZERO_ADR = 7'h00;
  // Qualifier bit meanings
  localparam logic EXT_MORE = 1'b0;
  localparam logic EXT_END = 1'b1;
  localparam logic CR_CMD = 1'b0;
  localparam logic CR_RSP = 1'b1;
  // Destination list limit and wide address byte index of the last byte
  localparam logic [4:0] DST_MAX = 5'h10;
  localparam logic [4:0] DST_NONE = 5'h00;
  localparam logic [1:0] BYTE_FIRST = 2'h0;
  localparam logic [1:0] BYTE_LAST = 2'h3;

  // Receiver states
  typedef enum logic [2:0] {
    PS_SRC = 3'h0,
    PS_SRC_ADR = 3'h1,
    PS_DST = 3'h2,
    PS_DST_ADR = 3'h3,
    PS_SKIP = 3'h4
  } lafc_rx_state_t;

  // Sender states
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_SRC_HEAD = 3'h1,
    HS_SRC_ADR = 3'h2,
    HS_DST_WAIT = 3'h3,
    HS_DST_HEAD = 3'h4,
    HS_DST_ADR = 3'h5
  } lafc_tx_state_t;
endpackage : lafc_pkg
`default_nettype wire

/* lafc_rx_end.sv */
// Receiving end: parses source and destination address fields
//
// Contract
// - Single-octet lists of 1 to 16 destinations
// - Qualifier in bit 0, address above
// - Wide addresses four octets, specials one
// - Marker octet precedes every wide address
// - Source marker: value 126 plus C/R
// - Destination marker: value 126 plus extension
// - Extension 0: another entry follows
// - Extension 1 ends the destination list
// - Wide lists of 1 to 16 entries
// - Type carried in seven address bits
// - C/R is 0 command, 1 response
// - Zero destination skipped, list continues
// - Single source octet: C/R plus address
// - Single destination octet: extension plus address
// - One addressing width for the whole net; in wide mode the code also sends and takes one-octet destinations
`timescale 1ns/10ps
`default_nettype none
module lafc_rx_end (
  input wire logic clk_sys,       // System clock
  input wire logic sys_rst,       // Synchronous reset
  lafc_link_if.rx link,           // Octet stream from peer
  input wire logic wide_mode,     // Four-octet addressing net
  input wire logic accept_en,     // Parser may take octets
  output logic src_valid,         // Source address pulse
  output logic [31:0] src_addr,   // Source address
  output logic src_cr,            // 0 command, 1 response
  output logic src_wide,          // Source was wide
  output logic dst_valid,         // Destination pulse
  output logic [31:0] dst_addr,   // Destination address
  output logic dst_wide,          // Destination was wide
  output logic done,              // List ended cleanly
  output logic err                // Address error, frame dropped
);
  lafc_pkg::lafc_rx_state_t state, next_state;
  logic [4:0] cnt, next_cnt;
  logic [1:0] bcnt, next_bcnt;
  logic [31:0] shreg, next_shreg;
  logic ext, next_ext, cr, next_cr;
  logic next_src_valid, next_src_cr, next_src_wide;
  logic next_dst_valid, next_dst_wide, next_done, next_err;
  logic [31:0] next_src_addr, next_dst_addr;
  logic f_valid, f_ready, take, lst, ent_done, ent_ext;
  logic [8:0] f_data;
  logic [7:0] oct;
  logic is_mark;

  // ----------------------------------------------------------------
  // Octet buffer
  // ----------------------------------------------------------------
  lafc_fifo #(
    .WIDTH(lafc_pkg::FIFO_W),
    .DEPTH(lafc_pkg::FIFO_D)
  ) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(link.oct_valid),
    .in_ready(link.oct_ready),
    .in_data({link.oct_last, link.oct_data}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // ----------------------------------------------------------------
  // Field parser
  // ----------------------------------------------------------------
  // Next state and output values
  always_comb
  begin
    f_ready = accept_en;
    take = f_valid & accept_en;
    oct = f_data[7:0];
    lst = f_data[lafc_pkg::LAST_BIT];
    is_mark = wide_mode && (oct[7:1] == lafc_pkg::MARK_VAL);
    next_state = state;
    next_cnt = cnt;
    next_bcnt = bcnt;
    next_shreg = shreg;
    next_ext = ext;
    next_cr = cr;
    next_src_valid = 1'b0;
    next_src_addr = src_addr;
    next_src_cr = src_cr;
    next_src_wide = src_wide;
    next_dst_valid = 1'b0;
    next_dst_addr = dst_addr;
    next_dst_wide = dst_wide;
    next_done = 1'b0;
    next_err = 1'b0;
    ent_done = 1'b0;
    ent_ext = ext;
    if (take)
    begin
      unique case (state)
        lafc_pkg::PS_SRC:
        begin
          next_cnt = lafc_pkg::DST_NONE;
          if (is_mark)
          begin
            next_cr = oct[0];
            next_bcnt = lafc_pkg::BYTE_FIRST;
            next_state = lafc_pkg::PS_SRC_ADR;
          end
          else
          begin
            next_src_valid = 1'b1;
            next_src_addr = {25'h0000000, oct[7:1]};
            next_src_cr = oct[0];
            next_src_wide = 1'b0;
            next_state = lafc_pkg::PS_DST;
          end
          if (lst)
          begin
            next_src_valid = 1'b0;
            next_err = 1'b1;
            next_state = lafc_pkg::PS_SRC;
          end
        end
        lafc_pkg::PS_SRC_ADR:
        begin
          next_shreg = {shreg[23:0], oct};
          next_bcnt = bcnt + 1'b1;
          if (bcnt == lafc_pkg::BYTE_LAST)
          begin
            next_src_valid = 1'b1;
            next_src_addr = {shreg[23:0], oct};
            next_src_cr = cr;
            next_src_wide = 1'b1;
            next_state = lafc_pkg::PS_DST;
          end
          if (lst)
          begin
            next_src_valid = 1'b0;
            next_err = 1'b1;
            next_state = lafc_pkg::PS_SRC;
          end
        end
        lafc_pkg::PS_DST:
        begin
          next_cnt = cnt + 1'b1;
          if (is_mark)
          begin
            next_ext = oct[0];
            next_bcnt = lafc_pkg::BYTE_FIRST;
            next_state = lafc_pkg::PS_DST_ADR;
            if (lst)
            begin
              next_err = 1'b1;
              next_state = lafc_pkg::PS_SRC;
            end
          end
          else
          begin
            ent_done = 1'b1;
            ent_ext = oct[0];
            if (oct[7:1] != lafc_pkg::ZERO_ADR)
            begin
              next_dst_valid = 1'b1;
              next_dst_addr = {25'h0000000, oct[7:1]};
              next_dst_wide = 1'b0;
            end
          end
        end
        lafc_pkg::PS_DST_ADR:
        begin
          next_shreg = {shreg[23:0], oct};
          next_bcnt = bcnt + 1'b1;
          if (bcnt == lafc_pkg::BYTE_LAST)
          begin
            ent_done = 1'b1;
            next_dst_valid = 1'b1;
            next_dst_addr = {shreg[23:0], oct};
            next_dst_wide = 1'b1;
          end
          else if (lst)
          begin
            next_err = 1'b1;
            next_state = lafc_pkg::PS_SRC;
          end
        end
        lafc_pkg::PS_SKIP:
        begin
          if (lst)
            next_state = lafc_pkg::PS_SRC;
        end
        default:
        begin
          next_state = lafc_pkg::PS_SRC;
        end
      endcase
      if (ent_done)
      begin
        if (ent_ext == lafc_pkg::EXT_END)
        begin
          next_done = 1'b1;
          next_state = lst ? lafc_pkg::PS_SRC : lafc_pkg::PS_SKIP;
        end
        else if (next_cnt == lafc_pkg::DST_MAX)
        begin
          next_dst_valid = 1'b0;
          next_err = 1'b1;
          next_state = lst ? lafc_pkg::PS_SRC : lafc_pkg::PS_SKIP;
        end
        else if (lst)
        begin
          next_dst_valid = 1'b0;
          next_err = 1'b1;
          next_state = lafc_pkg::PS_SRC;
        end
        else
        begin
          next_state = lafc_pkg::PS_DST;
        end
      end
    end
  end

  // Parser registers
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state <= lafc_pkg::PS_SRC;
      cnt <= lafc_pkg::DST_NONE;
      bcnt <= lafc_pkg::BYTE_FIRST;
      shreg <= '0;
      ext <= lafc_pkg::EXT_END;
      cr <= lafc_pkg::CR_CMD;
      src_valid <= 1'b0;
      src_addr <= '0;
      src_cr <= lafc_pkg::CR_CMD;
      src_wide <= 1'b0;
      dst_valid <= 1'b0;
      dst_addr <= '0;
      dst_wide <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      bcnt <= next_bcnt;
      shreg <= next_shreg;
      ext <= next_ext;
      cr <= next_cr;
      src_valid <= next_src_valid;
      src_addr <= next_src_addr;
      src_cr <= next_src_cr;
      src_wide <= next_src_wide;
      dst_valid <= next_dst_valid;
      dst_addr <= next_dst_addr;
      dst_wide <= next_dst_wide;
      done <= next_done;
      err <= next_err;
    end
  end
endmodule : lafc_rx_end
`default_nettype wire

/* lafc_tx_end.sv */
// Sending end: builds source and destination address fields
`timescale 1ns/10ps
`default_nettype none
module lafc_tx_end (
  input wire logic clk_sys,          // System clock
  input wire logic sys_rst,          // Synchronous reset
  lafc_link_if.tx link,              // Octet stream to peer
  input wire logic wide_mode,        // Four-octet addressing net
  input wire logic hdr_valid,        // Source descriptor offered
  output logic hdr_ready,            // Source descriptor taken
  input wire logic [31:0] hdr_src,   // Source address
  input wire logic hdr_cr,           // 0 command, 1 response
  input wire logic ent_valid,        // Destination offered
  output logic ent_ready,            // Destination taken
  input wire logic [31:0] ent_addr,  // Destination address
  input wire logic ent_wide,         // Entry is a wide address
  input wire logic ent_last          // Last destination
);
  lafc_pkg::lafc_tx_state_t state, next_state;
  logic [4:0] cnt, next_cnt;
  logic [1:0] bcnt, next_bcnt;
  logic [31:0] shreg, next_shreg;
  logic cr, next_cr, ext, next_ext, wide, next_wide;
  logic next_hdr_ready, next_ent_ready;
  logic next_valid, next_last, adv;
  logic [7:0] next_data;

  // Next state and link octet
  always_comb
  begin
    adv = !link.oct_valid || link.oct_ready;
    next_state = state;
    next_cnt = cnt;
    next_bcnt = bcnt;
    next_shreg = shreg;
    next_cr = cr;
    next_ext = ext;
    next_wide = wide;
    next_valid = link.oct_valid && !link.oct_ready;
    next_data = link.oct_data;
    next_last = link.oct_last;
    unique case (state)
      lafc_pkg::HS_IDLE:
      begin
        if (hdr_valid && hdr_ready)
        begin
          next_shreg = hdr_src;
          next_cr = hdr_cr;
          next_cnt = lafc_pkg::DST_NONE;
          next_state = lafc_pkg::HS_SRC_HEAD;
        end
      end
      lafc_pkg::HS_SRC_HEAD:
      begin
        if (adv)
        begin
          next_valid = 1'b1;
          next_last = 1'b0;
          next_bcnt = lafc_pkg::BYTE_FIRST;
          if (wide_mode)
          begin
            next_data = {lafc_pkg::MARK_VAL, cr};
            next_state = lafc_pkg::HS_SRC_ADR;
          end
          else
          begin
            next_data = {shreg[6:0], cr};
            next_state = lafc_pkg::HS_DST_WAIT;
          end
        end
      end
      lafc_pkg::HS_DST_WAIT:
      begin
        if (ent_valid && ent_ready)
        begin
          next_shreg = ent_addr;
          next_wide = ent_wide && wide_mode;
          next_cnt = cnt + 1'b1;
          next_ext = ent_last || (next_cnt == lafc_pkg::DST_MAX);
          next_state = lafc_pkg::HS_DST_HEAD;
        end
      end
      lafc_pkg::HS_DST_HEAD:
      begin
        if (adv)
        begin
          next_valid = 1'b1;
          next_bcnt = lafc_pkg::BYTE_FIRST;
          if (wide)
          begin
            next_data = {lafc_pkg::MARK_VAL, ext};
            next_last = 1'b0;
            next_state = lafc_pkg::HS_DST_ADR;
          end
          else
          begin
            next_data = {shreg[6:0], ext};
            next_last = ext;
            next_state = ext ? lafc_pkg::HS_IDLE : lafc_pkg::HS_DST_WAIT;
          end
        end
      end
      lafc_pkg::HS_SRC_ADR,
      lafc_pkg::HS_DST_ADR:
      begin
        if (adv)
        begin
          // Wide address goes out most significant octet first
          next_valid = 1'b1;
          next_data = shreg[31:24];
          next_shreg = {shreg[23:0], 8'h00};
          next_bcnt = bcnt + 1'b1;
          next_last = 1'b0;
          if (bcnt == lafc_pkg::BYTE_LAST)
          begin
            if (state == lafc_pkg::HS_SRC_ADR)
              next_state = lafc_pkg::HS_DST_WAIT;
            else
            begin
              next_last = ext;
              next_state = ext ? lafc_pkg::HS_IDLE : lafc_pkg::HS_DST_WAIT;
            end
          end
        end
      end
      default:
      begin
        next_state = lafc_pkg::HS_IDLE;
      end
    endcase
    next_hdr_ready = next_state == lafc_pkg::HS_IDLE;
    next_ent_ready = next_state == lafc_pkg::HS_DST_WAIT;
  end

  // Sender registers
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state <= lafc_pkg::HS_IDLE;
      cnt <= lafc_pkg::DST_NONE;
      bcnt <= lafc_pkg::BYTE_FIRST;
      shreg <= '0;
      cr <= lafc_pkg::CR_CMD;
      ext <= lafc_pkg::EXT_END;
      wide <= 1'b0;
      hdr_ready <= 1'b0;
      ent_ready <= 1'b0;
      link.oct_valid <= 1'b0;
      link.oct_data <= 8'h00;
      link.oct_last <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      bcnt <= next_bcnt;
      shreg <= next_shreg;
      cr <= next_cr;
      ext <= next_ext;
      wide <= next_wide;
      hdr_ready <= next_hdr_ready;
      ent_ready <= next_ent_ready;
      link.oct_valid <= next_valid;
      link.oct_data <= next_data;
      link.oct_last <= next_last;
    end
  end
endmodule : lafc_tx_end
`default_nettype wire

/* tb_top.sv */
// Self-checking bench joining the sending and receiving ends
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_sys, sys_rst, wide_mode, accept_en, stall, rnd_acc, err_b;
  logic hdr_valid, hdr_ready, hdr_cr, ent_valid, ent_ready, ent_wide;
  logic ent_last, src_valid, src_cr, src_wide, dst_valid, dst_wide;
  logic done, err;
  logic [31:0] hdr_src, ent_addr, src_addr, dst_addr;
  logic [33:0] src_q[$];
  logic [33:0] dst_q[$];
  int seed, mismatches, compares, exp_done, err_b_cnt;

  lafc_link_if u_lafc_link_if (.clk_sys(clk_sys));
  lafc_link_if u_lafc_link_if_b (.clk_sys(clk_sys));
  lafc_tx_end u_lafc_tx_end (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .link(u_lafc_link_if), .wide_mode(wide_mode), .hdr_valid(hdr_valid),
    .hdr_ready(hdr_ready), .hdr_src(hdr_src), .hdr_cr(hdr_cr),
    .ent_valid(ent_valid), .ent_ready(ent_ready), .ent_addr(ent_addr),
    .ent_wide(ent_wide), .ent_last(ent_last));
  lafc_rx_end u_lafc_rx_end (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .link(u_lafc_link_if), .wide_mode(wide_mode), .accept_en(accept_en),
    .src_valid(src_valid), .src_addr(src_addr), .src_cr(src_cr),
    .src_wide(src_wide), .dst_valid(dst_valid), .dst_addr(dst_addr),
    .dst_wide(dst_wide), .done(done), .err(err));
  // Second receiver fed by a faulty sender
  lafc_rx_end u_lafc_rx_end_b (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .link(u_lafc_link_if_b), .wide_mode(wide_mode), .accept_en(1'b1),
    .src_valid(), .src_addr(), .src_cr(), .src_wide(), .dst_valid(),
    .dst_addr(), .dst_wide(), .done(), .err(err_b));
  lafc_asserts u_lafc_asserts (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .oct_valid(u_lafc_link_if.oct_valid),
    .oct_ready(u_lafc_link_if.oct_ready),
    .oct_data(u_lafc_link_if.oct_data), .oct_last(u_lafc_link_if.oct_last));

  // Clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Parser stalls, random or held
  always @(posedge clk_sys)
    accept_en <= stall ? 1'b0 : (rnd_acc ? 1'($random(seed)) : 1'b1);

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  function automatic logic [33:0] pop(ref logic [33:0] q[$]);
    return (q.size() != 0) ? q.pop_front() : 'x;
  endfunction : pop

  function automatic logic [6:0] oct7();
    logic [6:0] v;
    v = 7'($random(seed));
    return (v == lafc_pkg::MARK_VAL) ? 7'h7f : v;
  endfunction : oct7

  // Results against the expected queues
  always @(negedge clk_sys)
  begin
    if (!sys_rst && src_valid === 1'b1)
      check({src_wide, src_cr, src_addr}, pop(src_q));
    if (!sys_rst && dst_valid === 1'b1)
      check({1'b0, dst_wide, dst_addr}, pop(dst_q));
    if (!sys_rst && done === 1'b1)
      exp_done--;
    if (!sys_rst && err !== 1'b0)
      check({33'h0, err}, 34'h0);
    if (err_b === 1'b1)
      err_b_cnt++;
  end

  task automatic wait_hi(input int w);
    int k;
    k = 0;
    do
    begin
      @(negedge clk_sys);
      k++;
    end while ((w == 0 ? hdr_ready : w == 1 ? ent_ready :
      u_lafc_link_if_b.oct_ready) !== 1'b1 && k < 500);
    if (k >= 500)
      mismatches++;
    @(posedge clk_sys);
  endtask : wait_hi

  task automatic send_frame(input int n);
    logic [31:0] s;
    logic [31:0] a;
    logic [6:0] v;
    logic c;
    logic w;
    s = $random(seed);
    c = 1'($random(seed));
    v = oct7();
    if (wide_mode)
      src_q.push_back({1'b1, c, s[31:7], v});
    else
      src_q.push_back({2'b0, c, 25'h0, v});
    exp_done++;
    hdr_src <= {s[31:7], v};
    hdr_cr <= c;
    hdr_valid <= 1'b1;
    wait_hi(0);
    hdr_valid <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      w = wide_mode & 1'($random(seed));
      v = (i % 5 == 2) ? 7'h00 : oct7();
      a = w ? ($random(seed) | 32'h80) : {25'($random(seed)), v};
      if (w)
        dst_q.push_back({2'b01, a});
      else if (v != 7'h00)
        dst_q.push_back({27'h0, v});
      ent_addr <= a;
      ent_wide <= w;
      ent_last <= (i == n - 1);
      ent_valid <= 1'b1;
      wait_hi(1);
    end
    ent_valid <= 1'b0;
  endtask : send_frame

  task automatic push_b(input logic [7:0] d, input logic l);
    u_lafc_link_if_b.oct_data <= d;
    u_lafc_link_if_b.oct_last <= l;
    u_lafc_link_if_b.oct_valid <= 1'b1;
    wait_hi(2);
  endtask : push_b

  task automatic drain(input string name);
    int k;
    k = 0;
    while ((src_q.size() + dst_q.size() != 0 || exp_done != 0) && k < 2000)
    begin
      @(negedge clk_sys);
      k++;
    end
    check(34'(src_q.size() + dst_q.size()), 34'h0);
    check(34'(exp_done), 34'h0);
    @(posedge clk_sys);
    $display("Test %s finished", name);
  endtask : drain

  task automatic reset_all();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
  endtask : reset_all

  task automatic conclude();
    $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  // Watchdog
  initial
  begin
    #(4 * 40000);
    mismatches++;
    conclude();
  end

  // Main sequence
  initial
  begin
    {seed, mismatches, compares, exp_done, err_b_cnt} = {32'd24, 128'd0};
    {sys_rst, wide_mode, stall, rnd_acc} = 4'b1000;
    {hdr_valid, hdr_src, hdr_cr, ent_valid, ent_addr} = '0;
    {ent_wide, ent_last} = 2'b00;
    u_lafc_link_if_b.oct_valid = 1'b0;
    u_lafc_link_if_b.oct_data = 8'h00;
    u_lafc_link_if_b.oct_last = 1'b0;
    reset_all();
    for (int n = 1; n <= 16; n++)
      send_frame(n);
    drain("single octet lists");
    wide_mode <= 1'b1;
    rnd_acc <= 1'b1;
    reset_all();
    for (int n = 1; n <= 16; n++)
      send_frame(n);
    drain("four octet lists");
    rnd_acc <= 1'b0;
    wide_mode <= 1'b0;
    reset_all();
    fork
      send_frame(16);
      begin
        stall <= 1'b1;
        repeat (40) @(negedge clk_sys);
        check({33'h0, u_lafc_link_if.oct_ready}, 34'h0);
        @(posedge clk_sys);
        stall <= 1'b0;
      end
    join
    drain("buffer full");
    push_b(8'h0a, 1'b0);
    push_b(8'h20, 1'b1);
    push_b(8'h0a, 1'b0);
    for (int i = 0; i < 17; i++)
      push_b(8'h08, i == 16);
    // Wide source marker cut after two address octets
    wide_mode <= 1'b1;
    push_b(8'hfc, 1'b0);
    push_b(8'h11, 1'b0);
    push_b(8'h22, 1'b1);
    u_lafc_link_if_b.oct_valid <= 1'b0;
    repeat (20) @(posedge clk_sys);
    check(34'(err_b_cnt), 34'h3);
    $display("Test faulty frames finished");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
